// *** core/drive_terminal_io_logic.sv ***
// drive terminal logic: start decoding on three input terminals and routing of status flags
// to two open-collector outputs and a relay output; avalon-mm slave for settings
// assumes terminal pins are asynchronous and status inputs share clk_sys_i
// Functional notes
// R1: stop method 0..100 or 1000..1100 coasts on start removal, else decelerates.
// R2: forward start only on first selector, reverse only on second selector.
// R3: hold input active enables self holding; start inputs become triggers.
// R4: in self holding a start pulse latches and running continues.
// R5: far side pulses the opposite input once to reverse.
// R6: hold input released once clears latch and decelerates to stop.
// R7: selector value 25 attaches hold function to that terminal.
// R8: inching active with inching enabled makes hold input ignored.
// R9: output stop shuts output but keeps self holding latch.
// R10: start decode tables for the two stop method groups.
// R11: output code 0..99 positive, 100..199 negative logic.
// R12: outputs reset to codes 0, 4 and 99.
// R13: codes 93 and 193 refused on relay selector.
// R14: 80,81,180,181 need safety variant; 68,168 also need external supply.
// R15: code 0 flag when output frequency at or above starting frequency; the code also requires a nonzero output frequency.
// R16: code 1 flag when output frequency reaches commanded frequency.
// R17: code 4 flag at threshold; separate threshold in reverse.
// R18: code 7 flag at 85 percent regen duty.
// R19: code 8 flag at 85 percent thermal level.
// R20: code 11 flag after reset processing, kept while startable or running.
// R21: codes 12 and 13 assert only after condition persists configured time.
// R22: code 46 asserts during power fail decel, latched until released.
// R23: latched direction follows most recent pulsed input.
// R24: methods 1000..1100 or 8888: forward starts, reverse selects direction.
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_io_logic
	import drive_io_pkg::*;
#(
	parameter int DETECT_CYCLES = DETECT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire term_pins_t pins_i,
	input wire drive_stat_t stat_i,
	output logic [1:0] run_cmd_o,
	output logic coast_o,
	output logic output_enable_o,
	output logic oc_a_o,
	output logic oc_b_o,
	output logic relay_o
);
	typedef struct packed {
		term_pins_t sync1;
		term_pins_t sync2;
		logic [15:0] stop_method;
		logic jog_en;
		logic safety_var;
		logic ext_sup_opt;
		logic [7:0] insel_a;
		logic [7:0] insel_b;
		logic [7:0] insel_c;
		logic [7:0] osel_a;
		logic [7:0] osel_b;
		logic [7:0] osel_c;
		logic fwd_prev;
		logic rev_prev;
		logic hold_prev;
		logic held;
		logic held_rev;
		logic pf_latch;
		logic [DET_W-1:0] cur_cnt;
		logic [DET_W-1:0] pow_cnt;
		logic [1:0] run_cmd;
		logic coast;
		logic oc_a;
		logic oc_b;
		logic relay;
		logic [31:0] rdata;
		logic rd_done;
	} state_t;

	state_t q, d;

	// flags indexed by code; absent codes read zero
	function automatic logic flag_of(input logic [7:0] code, input logic [63:0] flags);
		flag_of = (code < 8'd64) ? flags[code[5:0]] : 1'b0;
	endfunction

	// accepted codes per selector
	function automatic logic code_ok(input logic [7:0] code, input logic relay, input logic safety,
		input logic ext_sup);
		logic [7:0] base;
		base = (code >= NEG_OFFSET) ? code - NEG_OFFSET : code;
		code_ok = (code <= CODE_MAX);
		if (base == CODE_AVG_CUR && relay) begin
			code_ok = 1'b0; // see R13
		end
		if ((base == CODE_SAFE || base == CODE_SAFE2) && !safety) begin
			code_ok = 1'b0; // see R14
		end
		if (base == CODE_EXT_SUP && !(safety && ext_sup)) begin
			code_ok = 1'b0; // see R14
		end
	endfunction

	// drive one output from its selector code with polarity
	function automatic logic route(input logic [7:0] code, input logic [63:0] flags);
		if (code >= NEG_OFFSET) begin
			route = !flag_of(code - NEG_OFFSET, flags); // see R11
		end else begin
			route = flag_of(code, flags); // see R11
		end
	endfunction

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic be);
		merge8 = be ? nw : old;
	endfunction

	logic [63:0] flags;
	logic fwd_in, rev_in, hold_in, hold_assigned, self_hold;
	logic in_coast_range, in_dir_range;
	logic [7:0] pct85_regen, pct85_therm;
	logic [15:0] fth;
	logic [1:0] decoded;

	always_comb begin
		d = q;
		d.sync1 = pins_i;
		d.sync2 = q.sync1;
		// see R2 R7: forward only on terminal a, reverse only on terminal b, hold on any selector set to 25
		fwd_in = q.sync2.term_a && (q.insel_a == IN_FUNC_FWD);
		rev_in = q.sync2.term_b && (q.insel_b == IN_FUNC_REV);
		hold_assigned = (q.insel_a == IN_FUNC_HOLD) || (q.insel_b == IN_FUNC_HOLD) ||
			(q.insel_c == IN_FUNC_HOLD); // see R7
		hold_in = (q.insel_a == IN_FUNC_HOLD && q.sync2.term_a) ||
			(q.insel_b == IN_FUNC_HOLD && q.sync2.term_b) ||
			(q.insel_c == IN_FUNC_HOLD && q.sync2.term_c);
		// inching freezes the hold level, so neither its release nor inching itself clears the latch
		self_hold = hold_assigned && ((q.sync2.inching && q.jog_en) ? q.hold_prev : hold_in); // see R3 R8
		in_coast_range = (q.stop_method <= STOP_COAST_HI);
		in_dir_range = (q.stop_method >= STOP_DIR_LO) && (q.stop_method <= STOP_DIR_HI);
		// two-wire decode
		if (in_dir_range || q.stop_method == STOP_DIR_DEC) begin
			// see R10 R24: forward starts, reverse picks direction
			decoded = !fwd_in ? CMD_STOP : (rev_in ? CMD_REV : CMD_FWD);
		end else begin
			// see R10
			decoded = (fwd_in ^ rev_in) ? (fwd_in ? CMD_FWD : CMD_REV) : CMD_STOP;
		end
		d.fwd_prev = fwd_in;
		d.rev_prev = rev_in;
		d.hold_prev = self_hold;
		if (self_hold) begin
			// see R4 R23: pulse release latches the newest direction
			if (q.fwd_prev && !fwd_in) begin
				d.held = 1'b1;
				d.held_rev = 1'b0;
			end
			if (q.rev_prev && !rev_in) begin
				d.held = 1'b1;
				d.held_rev = 1'b1;
			end
			d.run_cmd = q.held ? (q.held_rev ? CMD_REV : CMD_FWD) : decoded;
		end else begin
			if (q.hold_prev) begin
				d.held = 1'b0; // see R6
			end
			d.run_cmd = decoded;
		end
		// see R1: coast only for the two timed ranges, decel otherwise
		d.coast = (d.run_cmd == CMD_STOP) && (in_coast_range || in_dir_range);
		// see R21: persistence counters
		d.cur_cnt = stat_i.current_over ? ((q.cur_cnt < DET_W'(DETECT_CYCLES)) ? q.cur_cnt + 1'b1 :
			q.cur_cnt) : '0;
		d.pow_cnt = stat_i.power_under ? ((q.pow_cnt < DET_W'(DETECT_CYCLES)) ? q.pow_cnt + 1'b1 :
			q.pow_cnt) : '0;
		// see R22: set wins over release
		if (stat_i.powerfail_decel) begin
			d.pf_latch = 1'b1;
		end else if (stat_i.powerfail_release) begin
			d.pf_latch = 1'b0;
		end
		pct85_regen = PREALARM_PCT;
		pct85_therm = PREALARM_PCT;
		fth = stat_i.reverse_rot ? stat_i.fth_rev : stat_i.fth_fwd; // see R17
		flags = '0;
		flags[CODE_RUN[5:0]] = (stat_i.out_freq >= stat_i.start_freq) && (stat_i.out_freq != 16'h0000); // see R15
		flags[CODE_AT_SPEED[5:0]] = (stat_i.out_freq == stat_i.set_freq); // see R16
		flags[CODE_OVERLOAD[5:0]] = stat_i.overload;
		flags[CODE_FREQ_TH[5:0]] = (stat_i.out_freq >= fth); // see R17
		flags[CODE_REGEN[5:0]] = (stat_i.regen_pct >= pct85_regen); // see R18
		flags[CODE_THERMAL[5:0]] = (stat_i.thermal_pct >= pct85_therm); // see R19
		flags[CODE_READY[5:0]] = stat_i.reset_done && !stat_i.fault; // see R20
		flags[CODE_CUR_HIGH[5:0]] = (q.cur_cnt >= DET_W'(DETECT_CYCLES)); // see R21
		flags[CODE_ZERO_CUR[5:0]] = (q.pow_cnt >= DET_W'(DETECT_CYCLES)); // see R21
		flags[CODE_PFAIL[5:0]] = q.pf_latch || stat_i.powerfail_decel; // see R22
		d.oc_a = route(q.osel_a, flags);
		d.oc_b = route(q.osel_b, flags);
		d.relay = (q.osel_c[7:0] == CODE_AVG_CUR) ? 1'b0 : route(q.osel_c, flags);
		if (q.osel_a == CODE_AVG_CUR || q.osel_a == CODE_AVG_CUR + NEG_OFFSET) begin
			d.oc_a = stat_i.avg_cur_pulse ^ (q.osel_a >= NEG_OFFSET);
		end
		if (q.osel_b == CODE_AVG_CUR || q.osel_b == CODE_AVG_CUR + NEG_OFFSET) begin
			d.oc_b = stat_i.avg_cur_pulse ^ (q.osel_b >= NEG_OFFSET);
		end
		if (q.osel_a == CODE_FAULT) d.oc_a = stat_i.fault;
		if (q.osel_b == CODE_FAULT) d.oc_b = stat_i.fault;
		if (q.osel_c == CODE_FAULT) d.relay = stat_i.fault;
		if (q.osel_c == CODE_FAULT + NEG_OFFSET) d.relay = !stat_i.fault;
		if (q.osel_a == CODE_SAFE || q.osel_a == CODE_SAFE + NEG_OFFSET)
			d.oc_a = stat_i.safe_active ^ (q.osel_a >= NEG_OFFSET);
		if (q.osel_b == CODE_SAFE2 || q.osel_b == CODE_SAFE2 + NEG_OFFSET)
			d.oc_b = stat_i.safe_ok ^ (q.osel_b >= NEG_OFFSET);
		// register bus
		d.rd_done = 1'b0;
		if (avs_write_i) begin
			unique case (avs_address_i)
				OFS_CTRL: begin
					d.stop_method[7:0] = merge8(q.stop_method[7:0], avs_writedata_i[7:0], avs_byteenable_i[0]);
					d.stop_method[15:8] = merge8(q.stop_method[15:8], avs_writedata_i[15:8], avs_byteenable_i[1]);
					if (avs_byteenable_i[2]) begin
						d.jog_en = avs_writedata_i[CTRL_JOG_EN_BIT];
						d.safety_var = avs_writedata_i[CTRL_SAFETY_BIT];
						d.ext_sup_opt = avs_writedata_i[CTRL_EXTSUP_BIT];
					end
				end
				OFS_INSEL: begin
					d.insel_a = merge8(q.insel_a, avs_writedata_i[7:0], avs_byteenable_i[0]);
					d.insel_b = merge8(q.insel_b, avs_writedata_i[15:8], avs_byteenable_i[1]);
					d.insel_c = merge8(q.insel_c, avs_writedata_i[23:16], avs_byteenable_i[2]);
				end
				OFS_OUTSEL: begin
					if (avs_byteenable_i[0] && code_ok(avs_writedata_i[7:0], 1'b0, q.safety_var, q.ext_sup_opt))
						d.osel_a = avs_writedata_i[7:0];
					if (avs_byteenable_i[1] && code_ok(avs_writedata_i[15:8], 1'b0, q.safety_var, q.ext_sup_opt))
						d.osel_b = avs_writedata_i[15:8];
					if (avs_byteenable_i[2] && code_ok(avs_writedata_i[23:16], 1'b1, q.safety_var, q.ext_sup_opt))
						d.osel_c = avs_writedata_i[23:16]; // see R13 R14
				end
				default: begin
				end
			endcase
		end
		if (avs_read_i && !q.rd_done) begin
			d.rd_done = 1'b1;
			unique case (avs_address_i)
				OFS_CTRL: d.rdata = {13'h0000, q.ext_sup_opt, q.safety_var, q.jog_en, q.stop_method};
				OFS_INSEL: d.rdata = {8'h00, q.insel_c, q.insel_b, q.insel_a};
				OFS_OUTSEL: d.rdata = {8'h00, q.osel_c, q.osel_b, q.osel_a};
				OFS_STATUS: d.rdata = {20'h00000, q.pf_latch, q.relay, q.oc_b, q.oc_a, q.coast,
					q.held_rev, q.held, self_hold, q.run_cmd, rev_in, fwd_in};
				default: d.rdata = 32'h00000000;
			endcase
		end
		if (sys_rst_i) begin
			d = '0;
			d.stop_method = STOP_METHOD_RST;
			d.insel_a = INSEL_A_RST;
			d.insel_b = INSEL_B_RST;
			d.insel_c = INSEL_C_RST;
			d.osel_a = OSEL_A_RST; // see R12
			d.osel_b = OSEL_B_RST; // see R12
			d.osel_c = OSEL_C_RST; // see R12
			d.run_cmd = CMD_STOP;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		q <= d;
	end

	assign avs_readdata_o = q.rdata;
	assign avs_waitrequest_o = avs_read_i && !q.rd_done;
	assign run_cmd_o = q.run_cmd;
	assign coast_o = q.coast;
	assign output_enable_o = !q.sync2.output_stop && (q.run_cmd != CMD_STOP); // see R9
	assign oc_a_o = q.oc_a;
	assign oc_b_o = q.oc_b;
	assign relay_o = q.relay;
endmodule
`default_nettype wire

// *** core/drive_io_pkg.sv ***
// package for the drive terminal logic: avalon register map, selector codes, flag layout
// assumes a 25 MHz system clock and a 32-bit avalon-mm slave with byte addresses
package drive_io_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int ADDR_W = 4;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_INSEL = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_OUTSEL = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
	// control register fields
	localparam int CTRL_STOP_LSB = 0;
	localparam int CTRL_JOG_EN_BIT = 16;
	localparam int CTRL_SAFETY_BIT = 17;
	localparam int CTRL_EXTSUP_BIT = 18;
	localparam logic [15:0] STOP_METHOD_RST = 16'h270f;
	// stop method ranges and special codes
	localparam logic [15:0] STOP_COAST_LO = 16'h0000;
	localparam logic [15:0] STOP_COAST_HI = 16'h0064;
	localparam logic [15:0] STOP_DIR_LO = 16'h03e8;
	localparam logic [15:0] STOP_DIR_HI = 16'h044c;
	localparam logic [15:0] STOP_DIR_DEC = 16'h22b8;
	// input selector codes
	localparam logic [7:0] IN_FUNC_HOLD = 8'h19;
	localparam logic [7:0] IN_FUNC_FWD = 8'h3c;
	localparam logic [7:0] IN_FUNC_REV = 8'h3d;
	localparam logic [7:0] INSEL_A_RST = 8'h3c;
	localparam logic [7:0] INSEL_B_RST = 8'h3d;
	localparam logic [7:0] INSEL_C_RST = 8'h19;
	// output selector codes
	localparam logic [7:0] NEG_OFFSET = 8'h64;
	localparam logic [7:0] OSEL_A_RST = 8'h00;
	localparam logic [7:0] OSEL_B_RST = 8'h04;
	localparam logic [7:0] OSEL_C_RST = 8'h63;
	localparam logic [7:0] CODE_RUN = 8'h00;
	localparam logic [7:0] CODE_AT_SPEED = 8'h01;
	localparam logic [7:0] CODE_OVERLOAD = 8'h03;
	localparam logic [7:0] CODE_FREQ_TH = 8'h04;
	localparam logic [7:0] CODE_REGEN = 8'h07;
	localparam logic [7:0] CODE_THERMAL = 8'h08;
	localparam logic [7:0] CODE_READY = 8'h0b;
	localparam logic [7:0] CODE_CUR_HIGH = 8'h0c;
	localparam logic [7:0] CODE_ZERO_CUR = 8'h0d;
	localparam logic [7:0] CODE_PFAIL = 8'h2e;
	localparam logic [7:0] CODE_EXT_SUP = 8'h44;
	localparam logic [7:0] CODE_SAFE = 8'h50;
	localparam logic [7:0] CODE_SAFE2 = 8'h51;
	localparam logic [7:0] CODE_AVG_CUR = 8'h5d;
	localparam logic [7:0] CODE_FAULT = 8'h63;
	localparam logic [7:0] CODE_MAX = 8'hc7;
	// analog thresholds in percent
	localparam logic [7:0] PREALARM_PCT = 8'h55;
	// detection persistence: time in ms and derived cycles
	localparam int DETECT_MS = 100;
	localparam int DETECT_CYC = (CLK_HZ / 1000) * DETECT_MS;
	localparam int DET_W = 22;
	localparam int RD_WAIT = 1;

	typedef enum logic [1:0] {
		CMD_STOP = 2'b00,
		CMD_FWD = 2'b01,
		CMD_REV = 2'b11
	} cmd_t;

	// analog and internal status arriving at the block, same clock
	typedef struct packed {
		logic [15:0] out_freq;
		logic [15:0] set_freq;
		logic [15:0] start_freq;
		logic [15:0] fth_fwd;
		logic [15:0] fth_rev;
		logic [7:0] regen_pct;
		logic [7:0] thermal_pct;
		logic current_over;
		logic power_under;
		logic powerfail_decel;
		logic powerfail_release;
		logic reset_done;
		logic fault;
		logic overload;
		logic safe_active;
		logic safe_ok;
		logic ext_supply;
		logic avg_cur_pulse;
		logic reverse_rot;
	} drive_stat_t;

	// raw terminal pins
	typedef struct packed {
		logic term_a;
		logic term_b;
		logic term_c;
		logic output_stop;
		logic inching;
	} term_pins_t;
endpackage

// *** tb/drive_io_properties.sv ***
// concurrent checks on the drive terminal block ports
// assumes the input selectors keep their reset values
`timescale 1ns/1ps
`default_nettype none
module drive_io_properties import drive_io_pkg::*; #(parameter int DETECT_CYCLES = 4) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire term_pins_t pins_i,
	input wire drive_stat_t stat_i,
	input wire logic [1:0] run_cmd_o,
	input wire logic coast_o,
	input wire logic output_enable_o,
	input wire logic relay_o
);
	logic [15:0] stop_q;
	logic dir_grp, coast_grp;
	logic [1:0] exp_cmd;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// shadow of the stop method, written with all lanes by the bench
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			stop_q <= STOP_METHOD_RST;
		end else if (avs_write_i && avs_address_i == OFS_CTRL && avs_byteenable_i[1:0] == 2'b11) begin
			stop_q <= avs_writedata_i[15:0];
		end
	end
	assign dir_grp = (stop_q >= STOP_DIR_LO && stop_q <= STOP_DIR_HI) || stop_q == STOP_DIR_DEC;
	assign coast_grp = stop_q <= STOP_COAST_HI || (stop_q >= STOP_DIR_LO && stop_q <= STOP_DIR_HI);
	always_comb begin
		exp_cmd = CMD_STOP;
		if (pins_i.term_a && (dir_grp || !pins_i.term_b)) exp_cmd = pins_i.term_b ? CMD_REV : CMD_FWD;
		else if (pins_i.term_b && !pins_i.term_a && !dir_grp) exp_cmd = CMD_REV;
	end
	sequence s_steady;
		$stable(pins_i) && $stable(stop_q) && !pins_i.term_c && !pins_i.inching;
	endsequence
	sequence s_read_start;
		$rose(avs_read_i);
	endsequence
	a_read_wait: assert property (s_read_start |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read wait state wrong");
	a_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
		else $error("write stalled");
	a_two_wire: assert property (s_steady [*4] |-> run_cmd_o == exp_cmd)
		else $error("start decode wrong");
	a_coast_sel: assert property ((run_cmd_o == CMD_STOP && !pins_i.output_stop && $stable(stop_q)) [*2]
		|-> coast_o == coast_grp) else $error("coast choice wrong");
	a_out_stop: assert property (pins_i.output_stop [*3] |-> !output_enable_o)
		else $error("output not shut off");
	a_stop_no_out: assert property (run_cmd_o == CMD_STOP |-> !output_enable_o)
		else $error("output on while stopped");
	a_cmd_code: assert property (run_cmd_o != 2'b10)
		else $error("illegal command code");
	a_relay_fault: assert property (1'b1 |=> relay_o == $past(stat_i.fault))
		else $error("relay not on fault");
endmodule
bind drive_terminal_io_logic drive_io_properties #(.DETECT_CYCLES(DETECT_CYCLES)) drive_io_properties_i (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i), .stat_i(stat_i), .run_cmd_o(run_cmd_o),
	.coast_o(coast_o), .output_enable_o(output_enable_o), .relay_o(relay_o));
`default_nettype wire

// *** tb/term_switches.sv ***
// model of the external switches wired to the terminal inputs
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ps
`default_nettype none
module term_switches import drive_io_pkg::*; (
	input wire logic clk_sys_i,
	output var term_pins_t pins_o
);
	initial pins_o = '0;
	// switches move just after an edge, then the synchroniser gets time to settle
	task automatic set_pins(input term_pins_t p);
		@(posedge clk_sys_i);
		pins_o <= p;
		repeat (6) @(posedge clk_sys_i);
	endtask
	// press one start input once and let go
	task automatic pulse(input logic rev);
		term_pins_t p;
		p = pins_o;
		if (rev) p.term_b = 1'b1;
		else p.term_a = 1'b1;
		set_pins(p);
		if (rev) p.term_b = 1'b0;
		else p.term_a = 1'b0;
		set_pins(p);
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the drive terminal block
// assumes the switch model owns the pins and the bench owns bus and status
`timescale 1ns/1ps
`default_nettype none
module tb_top import drive_io_pkg::*;;
	logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, rd = 1'b0, wr = 1'b0, e;
	logic wreq, out_en, oc_a, oc_b, relay, coast;
	logic [ADDR_W-1:0] adr = '0;
	logic [31:0] wd = '0, rdat, rdo;
	logic [3:0] be = 4'hf;
	logic [1:0] cmd, c;
	logic [15:0] m;
	logic [7:0] codes [5] = '{CODE_RUN, CODE_AT_SPEED, CODE_FREQ_TH, CODE_REGEN, CODE_THERMAL};
	term_pins_t pins, p;
	drive_stat_t st = '0, s;
	int n_fail = 0, checks = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	term_switches term_switches_i (.clk_sys_i(clk_sys_i), .pins_o(pins));
	drive_terminal_io_logic #(.DETECT_CYCLES(4)) drive_terminal_io_logic_i (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdo),
		.avs_waitrequest_o(wreq), .pins_i(pins), .stat_i(st), .run_cmd_o(cmd), .coast_o(coast),
		.output_enable_o(out_en), .oc_a_o(oc_a), .oc_b_o(oc_b), .relay_o(relay));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer; request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk_sys_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= b;
		do @(posedge clk_sys_i); while (wreq !== 1'b0);
		rdat = rdo;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	function automatic logic [1:0] start_cmd(input logic [15:0] sm, input logic a, input logic b);
		logic dir;
		dir = (sm >= STOP_DIR_LO && sm <= STOP_DIR_HI) || sm == STOP_DIR_DEC;
		if (a && b) return dir ? CMD_REV : CMD_STOP;
		if (a) return CMD_FWD;
		return (b && !dir) ? CMD_REV : CMD_STOP;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#(20000 * 40);
		n_fail++;
		print_verdict();
	end
	initial begin
		void'($urandom(47));
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		bus(OFS_CTRL, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h0000270f);
		bus(OFS_INSEL, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h00193d3c);
		bus(OFS_OUTSEL, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h00630400);
		bus(4'h2, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			case (i % 4)
				0: m = 16'($urandom % 101);
				1: m = STOP_METHOD_RST;
				2: m = STOP_DIR_LO + 16'($urandom % 101);
				default: m = STOP_DIR_DEC;
			endcase
			bus(OFS_CTRL, 1'b1, {16'h0, m}, 4'hf);
			p = '0;
			p.term_a = i[2];
			p.term_b = i[3];
			term_switches_i.set_pins(p);
			c = start_cmd(m, p.term_a, p.term_b);
			chk(cmd, c);
			chk(out_en, c != CMD_STOP);
			if (c == CMD_STOP) chk(coast, m <= STOP_COAST_HI || (m >= STOP_DIR_LO && m <= STOP_DIR_HI));
		end
		$display("test two wire done");
		bus(OFS_CTRL, 1'b1, 32'h0001270f, 4'hf);
		p = '0;
		p.term_c = 1'b1;
		term_switches_i.set_pins(p);
		term_switches_i.pulse(1'b0);
		chk(cmd, CMD_FWD);
		term_switches_i.pulse(1'b1);
		chk(cmd, CMD_REV);
		bus(OFS_STATUS, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h0000027c);
		p.output_stop = 1'b1;
		term_switches_i.set_pins(p);
		chk(out_en, 1'b0);
		p.output_stop = 1'b0;
		term_switches_i.set_pins(p);
		chk(cmd, CMD_REV);
		p.inching = 1'b1;
		term_switches_i.set_pins(p);
		p.term_c = 1'b0;
		term_switches_i.set_pins(p);
		chk(cmd, CMD_REV);
		p.term_c = 1'b1;
		term_switches_i.set_pins(p);
		p.inching = 1'b0;
		term_switches_i.set_pins(p);
		p.term_c = 1'b0;
		term_switches_i.set_pins(p);
		chk(cmd, CMD_STOP);
		$display("test self hold done");
		for (int i = 0; i < 20; i++) begin
			e = i[0];
			s = '0;
			s.out_freq = 16'($urandom % 32768) + 16'h0100;
			s.set_freq = e ? s.out_freq : s.out_freq + 16'h1;
			s.start_freq = s.set_freq;
			s.fth_fwd = s.set_freq;
			s.regen_pct = e ? PREALARM_PCT : PREALARM_PCT - 8'h1;
			s.thermal_pct = s.regen_pct;
			s.reset_done = 1'b1;
			s.fault = e;
			st <= s;
			bus(OFS_OUTSEL, 1'b1, {8'h0, CODE_FAULT, CODE_FREQ_TH, codes[i / 4] + (i[1] ? NEG_OFFSET : 8'h0)}, 4'hf);
			repeat (4) @(posedge clk_sys_i);
			chk(oc_a, e ^ i[1]);
			chk(oc_b, e);
			chk(relay, e);
		end
		bus(OFS_OUTSEL, 1'b1, 32'h005d0050, 4'hf);
		bus(OFS_OUTSEL, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h0063006c);
		bus(OFS_CTRL, 1'b1, 32'h0002270f, 4'hf);
		bus(OFS_OUTSEL, 1'b1, 32'h0000505d, 4'h3);
		bus(OFS_OUTSEL, 1'b1, 32'h00000044, 4'h1);
		bus(OFS_OUTSEL, 1'b0, 32'h0, 4'hf);
		chk(rdat, 32'h0063505d);
		bus(OFS_OUTSEL, 1'b1, {8'h0, CODE_FAULT, CODE_PFAIL, CODE_CUR_HIGH}, 4'hf);
		s = '0;
		s.current_over = 1'b1;
		s.powerfail_decel = 1'b1;
		st <= s;
		repeat (5) @(posedge clk_sys_i);
		chk(oc_a, 1'b0);
		@(posedge clk_sys_i);
		chk(oc_a, 1'b1);
		s.powerfail_decel = 1'b0;
		st <= s;
		repeat (3) @(posedge clk_sys_i);
		chk(oc_b, 1'b1);
		s.powerfail_release = 1'b1;
		st <= s;
		repeat (3) @(posedge clk_sys_i);
		chk(oc_b, 1'b0);
		$display("test output routing done");
		print_verdict();
	end
endmodule
`default_nettype wire
